// ---- design/fuse_pkg.sv ----
/*
  Shared constants for the fuse configuration loader: fuse offsets, field
  positions, codes, read masks, reset values and timing counts.
  Assumes a single 40 MHz core clock.
*/
package fuse_pkg;

  // ***********************************************************************
  // Fuse offsets
  // ***********************************************************************
  localparam logic [3:0] OFS_BROWNOUT = 4'h1;
  localparam logic [3:0] OFS_OSC      = 4'h2;
  localparam logic [3:0] OFS_TIMER    = 4'h4;
  localparam logic [3:0] OFS_SYS0     = 4'h5;
  localparam logic [3:0] OFS_SYS1     = 4'h6;
  localparam logic [3:0] OFS_APPLICATION_SECTION_END   = 4'h7;
  localparam logic [3:0] OFS_BOOT_SECTION_END  = 4'h8;
  localparam int         FUSE_COUNT   = 9;

  // ***********************************************************************
  // Field positions
  // ***********************************************************************
  localparam int BO_LEVEL_MSB  = 7;
  localparam int BO_LEVEL_LSB  = 5;
  localparam int BO_RATE_BIT   = 4;
  localparam int BO_ACTIVE_MSB = 3;
  localparam int BO_ACTIVE_LSB = 2;
  localparam int BO_SLEEP_MSB  = 1;
  localparam int BO_SLEEP_LSB  = 0;
  localparam int OSC_LOCK_BIT  = 7;
  localparam int OSC_FREQ_MSB  = 1;
  localparam int OSC_FREQ_LSB  = 0;
  localparam int CMP_EN_MSB    = 7;
  localparam int CMP_EN_LSB    = 4;
  localparam int CMP_LVL_MSB   = 3;
  localparam int CMP_LVL_LSB   = 0;
  localparam int CRC_MSB       = 7;
  localparam int CRC_LSB       = 6;
  localparam int PIN_MSB       = 3;
  localparam int PIN_LSB       = 2;
  localparam int KEEP_BIT      = 0;
  localparam int SUT_MSB       = 2;
  localparam int SUT_LSB       = 0;
  localparam int BLOCK_SHIFT   = 8;

  // ***********************************************************************
  // Read masks, reset values and codes
  // ***********************************************************************
  localparam logic [7:0] OSC_READ_MASK   = 8'h83;
  localparam logic [7:0] SYS0_READ_MASK  = 8'hcd;
  localparam logic [7:0] SYS1_READ_MASK  = 8'h07;
  localparam logic [7:0] SYS0_RESET      = 8'hc4;
  localparam logic [1:0] FREQ_16MHZ      = 2'h1;
  localparam logic [1:0] PIN_GPIO        = 2'h0;
  localparam logic [1:0] SCAN_DISABLED   = 2'h3;
  localparam int         TICK_W          = 10;
  localparam int         TRIM_W          = 8;
  localparam int         TEMP_TRIM_W     = 4;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int         CLK_HZ          = 40_000_000;
  localparam int         MS_PER_S        = 1000;
  localparam int         MS_CYCLES       = CLK_HZ / MS_PER_S;
  localparam int         LOW_RATE_HZ     = 32768;
  localparam int         LOW_RATE_CYCLES = (CLK_HZ + LOW_RATE_HZ - 1) / LOW_RATE_HZ;
  localparam logic [9:0] PIN_HOLD_TICKS  = 10'h300;

endpackage

// ---- design/timer_if.sv ----
/*
  Start/done handshake between the loader and a tick timer.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
interface timer_if;
  import fuse_pkg::*;
  logic              start;
  logic [TICK_W-1:0] ticks;
  logic              done;
  modport ctrl  (output start, output ticks, input done);
  modport timer (input start, input ticks, output done);
endinterface

// ---- design/tick_timer.sv ----
/*
  Tick timer: divides the core clock by DIV and counts a loaded number of
  slow ticks, then holds done high until the next start.
  Assumes a synchronous active-high reset on the core clock.
*/
`timescale 1ns/1ps
module tick_timer #(
  parameter int DIV = 40000
) (
  input wire logic core_clk,
  input wire logic reset,
  timer_if.timer   tmr
);
  import fuse_pkg::*;

  localparam int DW = $clog2(DIV) + 1;

  typedef struct packed {
    logic [DW-1:0]     div;
    logic [TICK_W-1:0] left;
    logic              done;
  } tmr_state_t;

  tmr_state_t state_reg;
  tmr_state_t state_next;

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  always_comb begin
    state_next = state_reg;
    if (reset) begin
      state_next = '0;
    end else if (tmr.start) begin
      state_next.div  = '0;
      state_next.left = tmr.ticks;
      state_next.done = (tmr.ticks == '0);
    end else if (!state_reg.done) begin
      if (state_reg.div == DW'(DIV - 1)) begin
        state_next.div  = '0;
        state_next.left = state_reg.left - 1'b1;
        if (state_reg.left == TICK_W'(1)) begin
          state_next.done = 1'b1;
        end
      end else begin
        state_next.div = state_reg.div + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    state_reg <= state_next;
  end

  assign tmr.done = state_reg.done;

endmodule

// ---- design/fuse_config_loader.sv ----
/*
  Fuse configuration loader: waits out the start-up delay after reset,
  then copies fuse fields into peripheral control outputs, and serves
  read-only fuse reads.
  Assumes the fuse image is stable while reset is released and that
  power_on_reset is high during reset only when the reset is a power-on.
*/
// Overview of operation
// - Brown-out settings reload only after a power-on reset, held otherwise.
// - Fuse bits 7:5 copied to brown-out level; 0x2 is 2.6V, 0x7 4.2V.
// - Fuse bit 4 copied to sample rate: 0 is 1 kHz, 1 is 125 Hz.
// - Bits 3:2 give active mode: off, on, sampled, on with wake-up held.
// - Bits 1:0 give sleep mode: off, on, sampled; code 3 reserved.
// - Oscillator bit 7 copied to calibration lock; 1 locks calibration.
// - Frequency select picks factory trims; only code 0x1, 16 MHz, is valid.
// - Every timer fuse bit copied into the timer fault control register.
// - Timer compare settings reload only after power-on reset, kept otherwise.
// - Bits 7:4 enable compare pin outputs D down to A.
// - Bits 3:0 give default compare levels, applied after reset and on debug.
// - Bits 7:6 select scan range: flash, boot, boot plus code, none.
// - Bits 3:2 set shared pin: I/O, debug port, reset; 0x3 reserved.
// - As I/O, pin driver stays off 768 slow oscillator cycles after reset.
// - Bit 0 keeps EEPROM on erase, but a locked device always erases.
// - Start-up code 0 to 7 gives 0, 1, 2, 4 ... 64 ms delay.
// - Application end in 256-byte blocks; zero means code to flash end.
// - Boot end in 256-byte blocks; zero makes the whole flash boot.
// - Both section bytes zero make the entire flash boot section.
// - Fuse values reach their targets at the end of the start-up sequence.
// - A newly programmed fuse takes effect only at the next reset; brown-out and timer fuses only at the next power-on reset.
`timescale 1ns/1ps
module fuse_config_loader #(
  parameter int                MS_DIV       = fuse_pkg::MS_CYCLES,
  parameter int                LOW_RATE_DIV = fuse_pkg::LOW_RATE_CYCLES,
  parameter int                ADDR_W       = 17,
  parameter logic [ADDR_W-1:0] FLASH_END    = ADDR_W'(32'h10000)
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  reset,
  input  wire logic                                  power_on_reset,
  input  wire logic [fuse_pkg::FUSE_COUNT-1:0][7:0]  fuse_image,
  input  wire logic [fuse_pkg::TRIM_W-1:0]           factory_trim_in,
  input  wire logic [fuse_pkg::TEMP_TRIM_W-1:0]      factory_temp_trim_in,
  input  wire logic                                  device_locked,
  input  wire logic                                  debug_enter,
  input  wire logic                                  fault_detect_setting,
  input  wire logic [3:0]                            reg_addr,
  input  wire logic                                  reg_read,
  input  wire logic                                  reg_write,
  input  wire logic [7:0]                            reg_wdata,
  output logic [7:0]                                 reg_rdata,
  output logic                                       reg_read_valid,
  output logic [2:0]                                 brownout_level,
  output logic                                       brownout_sample_rate,
  output logic [1:0]                                 brownout_active_mode,
  output logic [1:0]                                 brownout_sleep_mode,
  output logic                                       osc_cal_lock,
  output logic [1:0]                                 osc_frequency_select,
  output logic                                       osc_frequency_valid,
  output logic [fuse_pkg::TRIM_W-1:0]                main_osc_trim,
  output logic [fuse_pkg::TEMP_TRIM_W-1:0]           main_osc_temp_trim,
  output logic [7:0]                                 timer_fault_control,
  output logic [3:0]                                 compare_pin_enable,
  output logic [3:0]                                 compare_default_level,
  output logic                                       compare_default_apply,
  output logic [1:0]                                 crc_scan_source,
  output logic                                       scan_disabled,
  output logic [1:0]                                 shared_pin_function,
  output logic                                       pin_driver_enable,
  output logic                                       eeprom_keep_on_erase,
  output logic [ADDR_W-1:0]                          boot_section_end,
  output logic [ADDR_W-1:0]                          app_code_end,
  output logic                                       config_loaded
);
  import fuse_pkg::*;

  // ***********************************************************************
  // State
  // ***********************************************************************
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_LOAD  = 4'b0100,
    ST_RUN   = 4'b1000
  } phase_t;

  typedef struct packed {
    phase_t                 phase;
    logic                   por_seen;
    logic [2:0]             bo_level;
    logic                   bo_rate;
    logic [1:0]             bo_active;
    logic [1:0]             bo_sleep;
    logic                   osc_lock;
    logic [1:0]             osc_freq;
    logic                   osc_valid;
    logic [TRIM_W-1:0]      osc_trim;
    logic [TEMP_TRIM_W-1:0] osc_temp_trim;
    logic [7:0]             fault_ctrl;
    logic                   cmp_apply;
    logic [1:0]             crc_src;
    logic                   scan_off;
    logic [1:0]             pin_func;
    logic                   drive_ok;
    logic                   keep_fuse;
    logic                   eeprom_keep;
    logic [ADDR_W-1:0]      boot_end;
    logic [ADDR_W-1:0]      app_end;
    logic [7:0]             rdata;
    logic                   rvalid;
    logic                   loaded;
  } loader_state_t;

  loader_state_t state_reg;
  loader_state_t state_next;

  timer_if boot_tmr ();
  timer_if pin_tmr ();

  logic [7:0] boot_byte;
  logic [7:0] app_byte;

  assign boot_byte = fuse_image[OFS_BOOT_SECTION_END];
  assign app_byte  = fuse_image[OFS_APPLICATION_SECTION_END];

  // ***********************************************************************
  // Helpers
  // ***********************************************************************
  function automatic logic [TICK_W-1:0] startup_ticks(input logic [2:0] code);
    logic [TICK_W-1:0] t;
    t = '0;
    if (code != 3'h0) begin
      t = TICK_W'(1) << (code - 3'h1);
    end
    return t;
  endfunction

  function automatic logic [7:0] read_fuse(input logic [3:0] addr);
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      OFS_BROWNOUT, OFS_TIMER, OFS_APPLICATION_SECTION_END, OFS_BOOT_SECTION_END: d = fuse_image[addr];
      OFS_OSC:  d = fuse_image[addr] & OSC_READ_MASK;
      OFS_SYS0: d = fuse_image[addr] & SYS0_READ_MASK;
      OFS_SYS1: d = fuse_image[addr] & SYS1_READ_MASK;
      default:  d = 8'h00;
    endcase
    return d;
  endfunction

  // ***********************************************************************
  // Timers
  // ***********************************************************************
  // Start-up delay length.
  assign boot_tmr.start = (state_reg.phase == ST_RESET) && !reset;
  assign boot_tmr.ticks = startup_ticks(fuse_image[OFS_SYS1][SUT_MSB:SUT_LSB]);
  assign pin_tmr.start  = (state_reg.phase == ST_RESET) && !reset;
  assign pin_tmr.ticks  = PIN_HOLD_TICKS;

  tick_timer #(.DIV(MS_DIV)) u_boot_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .tmr      (boot_tmr)
  );

  tick_timer #(.DIV(LOW_RATE_DIV)) u_pin_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .tmr      (pin_tmr)
  );

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  always_comb begin
    state_next           = state_reg;
    state_next.rvalid    = 1'b0;
    state_next.cmp_apply = 1'b0;
    if (reset) begin
      state_next.phase    = ST_RESET;
      state_next.por_seen = (state_reg.phase != ST_RESET) ? power_on_reset
                                                          : state_reg.por_seen | power_on_reset;
      state_next.osc_lock      = 1'b0;
      state_next.osc_freq      = 2'h0;
      state_next.osc_valid     = 1'b0;
      state_next.osc_trim      = '0;
      state_next.osc_temp_trim = '0;
      state_next.crc_src       = SYS0_RESET[CRC_MSB:CRC_LSB];
      state_next.scan_off      = 1'b0;
      state_next.pin_func      = SYS0_RESET[PIN_MSB:PIN_LSB];
      state_next.drive_ok      = 1'b0;
      state_next.keep_fuse     = SYS0_RESET[KEEP_BIT];
      state_next.eeprom_keep   = 1'b0;
      state_next.boot_end      = FLASH_END;
      state_next.app_end       = FLASH_END;
      state_next.rdata         = 8'h00;
      state_next.loaded        = 1'b0;
      // Only a power-on clears the brown-out setup.
      if (power_on_reset) begin
        state_next.bo_level   = 3'h0;
        state_next.bo_rate    = 1'b0;
        state_next.bo_active  = 2'h0;
        state_next.bo_sleep   = 2'h0;
        // Only a power-on clears the timer setup.
        state_next.fault_ctrl = 8'h00;
      end
    end else begin
      state_next.eeprom_keep = state_reg.keep_fuse & ~device_locked;
      state_next.drive_ok = state_reg.loaded && (state_reg.pin_func == PIN_GPIO)
                            && pin_tmr.done;
      if (reg_read) begin
        state_next.rvalid = 1'b1;
        state_next.rdata  = read_fuse(reg_addr);
      end
      case (state_reg.phase)
        ST_RESET: begin
          state_next.phase = ST_WAIT;
        end
        ST_WAIT: begin
          if (boot_tmr.done) begin
            state_next.phase = ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_next.phase  = ST_RUN;
          state_next.loaded = 1'b1;
          if (state_reg.por_seen) begin
            state_next.bo_level  = fuse_image[OFS_BROWNOUT][BO_LEVEL_MSB:BO_LEVEL_LSB];
            state_next.bo_rate   = fuse_image[OFS_BROWNOUT][BO_RATE_BIT];
            state_next.bo_active = fuse_image[OFS_BROWNOUT][BO_ACTIVE_MSB:BO_ACTIVE_LSB];
            state_next.bo_sleep  = fuse_image[OFS_BROWNOUT][BO_SLEEP_MSB:BO_SLEEP_LSB];
            state_next.fault_ctrl = fuse_image[OFS_TIMER];
          end
          state_next.osc_lock  = fuse_image[OFS_OSC][OSC_LOCK_BIT];
          state_next.osc_freq  = fuse_image[OFS_OSC][OSC_FREQ_MSB:OSC_FREQ_LSB];
          state_next.osc_valid = (fuse_image[OFS_OSC][OSC_FREQ_MSB:OSC_FREQ_LSB]
                                  == FREQ_16MHZ);
          if (fuse_image[OFS_OSC][OSC_FREQ_MSB:OSC_FREQ_LSB] == FREQ_16MHZ) begin
            state_next.osc_trim      = factory_trim_in;
            state_next.osc_temp_trim = factory_temp_trim_in;
          end
          state_next.cmp_apply = 1'b1;
          state_next.crc_src   = fuse_image[OFS_SYS0][CRC_MSB:CRC_LSB];
          state_next.scan_off  = (fuse_image[OFS_SYS0][CRC_MSB:CRC_LSB] == SCAN_DISABLED);
          state_next.pin_func  = fuse_image[OFS_SYS0][PIN_MSB:PIN_LSB];
          state_next.keep_fuse = fuse_image[OFS_SYS0][KEEP_BIT];
          if (boot_byte == 8'h00) begin
            state_next.boot_end = FLASH_END;
          end else begin
            state_next.boot_end = ADDR_W'(boot_byte) << BLOCK_SHIFT;
          end
          if (app_byte == 8'h00) begin
            state_next.app_end = FLASH_END;
          end else begin
            state_next.app_end = ADDR_W'(app_byte) << BLOCK_SHIFT;
          end
        end
        ST_RUN: begin
          if (debug_enter && fault_detect_setting) begin
            state_next.cmp_apply = 1'b1;
          end
        end
        default: begin
          state_next.phase = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    state_reg <= state_next;
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  assign reg_rdata             = state_reg.rdata;
  assign reg_read_valid        = state_reg.rvalid;
  assign brownout_level        = state_reg.bo_level;
  assign brownout_sample_rate  = state_reg.bo_rate;
  assign brownout_active_mode  = state_reg.bo_active;
  assign brownout_sleep_mode   = state_reg.bo_sleep;
  assign osc_cal_lock          = state_reg.osc_lock;
  assign osc_frequency_select  = state_reg.osc_freq;
  assign osc_frequency_valid   = state_reg.osc_valid;
  assign main_osc_trim         = state_reg.osc_trim;
  assign main_osc_temp_trim    = state_reg.osc_temp_trim;
  assign timer_fault_control   = state_reg.fault_ctrl;
  // Pin enables D down to A.
  assign compare_pin_enable    = state_reg.fault_ctrl[CMP_EN_MSB:CMP_EN_LSB];
  assign compare_default_level = state_reg.fault_ctrl[CMP_LVL_MSB:CMP_LVL_LSB];
  assign compare_default_apply = state_reg.cmp_apply;
  assign crc_scan_source       = state_reg.crc_src;
  assign scan_disabled         = state_reg.scan_off;
  assign shared_pin_function   = state_reg.pin_func;
  assign pin_driver_enable     = state_reg.drive_ok;
  assign eeprom_keep_on_erase  = state_reg.eeprom_keep;
  assign boot_section_end      = state_reg.boot_end;
  assign app_code_end          = state_reg.app_end;
  assign config_loaded         = state_reg.loaded;

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  logic in_load;
  assign in_load = (state_reg.phase == ST_LOAD);

  AST_BO_HOLD: assert property (in_load && !state_reg.por_seen |=>
    $stable(brownout_level) && $stable(brownout_active_mode))
    else $error("brownout setup changed after a non power-on reset");
  AST_BO_LEVEL: assert property (in_load && state_reg.por_seen |=>
    brownout_level == $past(fuse_image[OFS_BROWNOUT][BO_LEVEL_MSB:BO_LEVEL_LSB]))
    else $error("brownout level not copied from fuse");
  AST_BO_MODES: assert property (in_load && state_reg.por_seen |=>
    {brownout_sample_rate, brownout_active_mode, brownout_sleep_mode}
    == $past(fuse_image[OFS_BROWNOUT][BO_RATE_BIT:BO_SLEEP_LSB]))
    else $error("brownout rate or modes not copied");
  AST_OSC_VALID: assert property (in_load |=>
    osc_frequency_valid == (osc_frequency_select == FREQ_16MHZ) && osc_cal_lock
    == $past(fuse_image[OFS_OSC][OSC_LOCK_BIT]))
    else $error("oscillator fields wrong after load");
  AST_TIMER_HOLD: assert property (in_load && !state_reg.por_seen |=>
    $stable(timer_fault_control))
    else $error("timer setup changed after a non power-on reset");
  AST_DEBUG_APPLY: assert property ((state_reg.phase == ST_RUN) && debug_enter
    && fault_detect_setting |=> compare_default_apply)
    else $error("defaults not applied on debug entry");
  AST_PIN_HOLD: assert property (pin_driver_enable |->
    $past(pin_tmr.done) && shared_pin_function == PIN_GPIO)
    else $error("pin driver enabled during hold-off");
  AST_KEEP_LOCK: assert property (device_locked ##1 device_locked |->
    !eeprom_keep_on_erase)
    else $error("eeprom kept on a locked device");
  AST_BOOT_ALL: assert property (in_load && boot_byte == 8'h00 && app_byte == 8'h00
    |=> boot_section_end == FLASH_END && app_code_end == FLASH_END)
    else $error("zero section bytes did not make all flash boot");
  AST_WAIT_LOAD: assert property ((state_reg.phase == ST_WAIT) && boot_tmr.done
    |=> in_load ##1 config_loaded)
    else $error("load did not follow the start-up delay");
  AST_WRITE_IGNORED: assert property (reg_write && state_reg.phase == ST_RUN
    && !debug_enter |=> $stable(timer_fault_control) && $stable(boot_section_end))
    else $error("register write changed a target");

  COV_POR_LOAD: cover property (in_load && state_reg.por_seen);
  COV_WARM_LOAD: cover property (in_load && !state_reg.por_seen);
  COV_DEBUG: cover property (debug_enter && fault_detect_setting ##1 compare_default_apply);
  COV_READ: cover property (reg_read ##1 reg_read_valid);

endmodule

// ---- testbench/peripheral_targets.sv ----
/*
  Target control registers of the brown-out detector and motor timer.
  Assumes the loader outputs settle on the core clock before config_loaded.
*/
`timescale 1ns/1ps
module peripheral_targets (
  input  wire logic       core_clk,
  input  wire logic       config_loaded,
  input  wire logic [2:0] brownout_level,
  input  wire logic [7:0] timer_fault_control,
  output logic      [2:0] tgt_level_reg,
  output logic      [7:0] tgt_fault_reg
);
  always_ff @(posedge core_clk) begin
    if (config_loaded) begin
      tgt_level_reg <= brownout_level;
      tgt_fault_reg <= timer_fault_control;
    end
  end
endmodule

// ---- testbench/test_fuse_config_loader.sv ----
/*
  Self-checking bench for the fuse loader with its peripheral targets.
  Assumes shortened counts: MS_DIV 4, LOW_RATE_DIV 2.
*/
`timescale 1ns/1ps
module test_fuse_config_loader;
  import fuse_pkg::*;
  logic core_clk = 0, reset = 1, power_on_reset = 1, reg_read = 0, reg_write = 0;
  logic device_locked = 1, debug_enter = 0, fault_detect_setting = 0;
  logic [FUSE_COUNT-1:0][7:0] fuse_image = '0;
  logic [7:0] factory_trim_in = 8'h5a, reg_wdata = 8'hff, reg_rdata, main_osc_trim;
  logic [7:0] timer_fault_control, tgt_fault_reg;
  logic [3:0] factory_temp_trim_in = 4'h9, reg_addr = 4'h0, main_osc_temp_trim;
  logic [3:0] compare_pin_enable, compare_default_level;
  logic [2:0] brownout_level, tgt_level_reg;
  logic [1:0] brownout_active_mode, brownout_sleep_mode, osc_frequency_select;
  logic [1:0] crc_scan_source, shared_pin_function;
  logic brownout_sample_rate, osc_cal_lock, osc_frequency_valid, compare_default_apply;
  logic scan_disabled, pin_driver_enable, eeprom_keep_on_erase, config_loaded, reg_read_valid;
  logic [16:0] boot_section_end, app_code_end;
  int num_errors = 0, check_count = 0;
  fuse_config_loader #(.MS_DIV(4), .LOW_RATE_DIV(2)) dut_u (.*);
  peripheral_targets tgt_u (.*);
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic por, input int exp_n);
    int n;
    n = 0;
    @(negedge core_clk);
    reset = 1;
    power_on_reset = por;
    repeat (12) @(negedge core_clk);
    reset = 0;
    power_on_reset = 0;
    while (config_loaded !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > 200) begin
        chk(0, 1);
        wrap_up();
      end
    end
    chk(17'(n), 17'(exp_n));
    chk(compare_default_apply, 1);
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_read = 1;
    @(negedge core_clk);
    reg_read = 0;
    chk(reg_read_valid, 1);
    chk(reg_rdata, exp);
    @(negedge core_clk);
    chk(reg_read_valid, 0);
  endtask
  task automatic s_power_on;
    fuse_image = {8'h00, 8'h00, 8'h01, 8'h31, 8'ha5, 8'h00, 8'h81, 8'h5e, 8'h00};
    do_reset(1, 7);
    chk({brownout_level, brownout_sample_rate, brownout_active_mode}, 6'h17);
    chk(brownout_sleep_mode, 2'h2);
    chk({osc_cal_lock, osc_frequency_valid, main_osc_trim}, 10'h35a);
    chk(main_osc_temp_trim, 4'h9);
    chk({compare_pin_enable, compare_default_level}, 8'ha5);
    chk(tgt_fault_reg, 8'ha5);
    chk({crc_scan_source, scan_disabled, shared_pin_function}, 5'h00);
    chk(eeprom_keep_on_erase, 0);
    chk(boot_section_end, 17'h10000);
    chk(app_code_end, 17'h10000);
    reg_write = 1;
    rd(4'h5, 8'h01);
    reg_write = 0;
    rd(4'h3, 8'h00);
    repeat (1500) @(negedge core_clk);
    chk(pin_driver_enable, 0);
    repeat (100) @(negedge core_clk);
    chk(pin_driver_enable, 1);
  endtask
  task automatic s_warm;
    fuse_image = {8'h04, 8'h08, 8'h00, 8'hc9, 8'h0f, 8'h00, 8'h02, 8'he0, 8'h00};
    device_locked = 0;
    chk(brownout_level, 3'h2);
    do_reset(0, 3);
    chk(tgt_level_reg, 3'h2);
    chk(timer_fault_control, 8'ha5);
    chk({osc_cal_lock, osc_frequency_valid, main_osc_trim}, 10'h000);
    chk(osc_frequency_select, 2'h2);
    chk({crc_scan_source, scan_disabled, shared_pin_function}, 5'h1e);
    chk(eeprom_keep_on_erase, 1);
    chk(boot_section_end, 17'h00400);
    chk(app_code_end, 17'h00800);
    fault_detect_setting = 1;
    debug_enter = 1;
    @(negedge core_clk);
    debug_enter = 0;
    chk(compare_default_apply, 1);
    @(negedge core_clk);
    chk(compare_default_apply, 0);
    chk(pin_driver_enable, 0);
  endtask
  initial begin
    s_power_on();
    s_warm();
    wrap_up();
  end
endmodule
